/* File: pkg/supervisor_pkg.sv */
package supervisor_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned RESET_HOLD_MS   = 500;
   localparam int unsigned WDOG_NOM_MS     = 700;
   localparam int unsigned WDOG_MIN_MS     = 500;
   localparam int unsigned WDOG_MAX_MS     = 900;
   localparam int unsigned STROBE_MIN_NS   = 500;
   localparam int unsigned DEBOUNCE_US     = 10_000;
   localparam int unsigned TICK_US         = 1000;
   // ==========================================================
   // derived counts: one millisecond tick drives the long timers
   localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned STROBE_CYC      =
      (STROBE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned DEBOUNCE_TICKS  = DEBOUNCE_US / TICK_US;
   localparam int unsigned CNT_W           = 24;
   // ==========================================================
   // pulse states
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_RUN  = 3'b010,
      ST_PUSH = 3'b100
   } sup_state_e;
endpackage

/* File: pkg/tick_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface
`default_nettype wire

/* File: core/tick_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = supervisor_pkg::TICK_CYC
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   tick_if.src       tk
);
   import supervisor_pkg::*;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             tick_q;
   logic             tick_d;

   always_comb begin
      tick_d = (cnt_q == CNT_W'(DIV - 1));
      cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tk.tick = tick_q;
endmodule
`default_nettype wire

/* File: core/supply_watchdog_reset_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - pin pulled low at once while supply is below threshold
// - pin held low at least 500 ms after supply recovers
// - watchdog time-out nominally 700 ms, within 500 to 900 ms
// - missed strobe gives a reset pulse of at least 500 ms
// - pulses repeat every time-out until a strobe arrives
// - sensed strobe band restarts the watchdog timer
// - external low is debounced, bounce is not separate events
// - external low held past the debounce time, however long, gives at least 500 ms reset
// - open-drain output only, pin never driven high
// - deep low is push-button reset, high is no request
module supply_watchdog_reset_supervisor #(
   parameter int unsigned TICK_CYC   = supervisor_pkg::TICK_CYC,
   parameter int unsigned HOLD_TICKS = supervisor_pkg::RESET_HOLD_MS,
   parameter int unsigned WDOG_TICKS = supervisor_pkg::WDOG_NOM_MS,
   parameter int unsigned DEB_TICKS  = supervisor_pkg::DEBOUNCE_TICKS,
   parameter int unsigned STB_CYC    = supervisor_pkg::STROBE_CYC
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic supply_good,
   input  wire logic strobe_low_level,
   input  wire logic push_button_reset,
   output var  logic reset_strobe_pin_o,
   output var  logic reset_strobe_pin_oe,
   output var  logic wdog_expired
);
   import supervisor_pkg::*;

   // ==========================================================
   // input synchronisers (pin comparators are asynchronous)
   logic [1:0] sg_q;
   logic [1:0] stb_q;
   logic [1:0] pb_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sg_q  <= '0;
         stb_q <= '0;
         pb_q  <= '0;
      end else begin
         sg_q  <= {sg_q[0], supply_good};
         stb_q <= {stb_q[0], strobe_low_level};
         pb_q  <= {pb_q[0], push_button_reset};
      end
   end

   // raw supply_good also feeds the pin directly so the pull-down
   // has no synchroniser latency on a brown-out
   wire supply_ok = sg_q[1];

   tick_if tk ();
   tick_divider #(.DIV(TICK_CYC)) u_div (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .tk      (tk)
   );

   // ==========================================================
   // state and counters
   sup_state_e       st_q,  st_d;
   logic [CNT_W-1:0] hold_q, hold_d;
   logic [CNT_W-1:0] wd_q,   wd_d;
   logic [CNT_W-1:0] deb_q,  deb_d;
   logic [CNT_W-1:0] sw_q,   sw_d;
   logic             pin_q,  pin_d;
   logic             exp_q,  exp_d;
   logic             strobe_ok;
   logic             pb_seen;

   always_comb begin
      st_d      = st_q;
      hold_d    = hold_q;
      wd_d      = wd_q;
      deb_d     = deb_q;
      sw_d      = sw_q;
      exp_d     = exp_q;
      strobe_ok = 1'b0;
      pb_seen   = 1'b0;
      // strobe width filter: only a band low of STB_CYC counts
      if (stb_q[1] && !pin_q && !pb_q[1]) begin
         if (sw_q != CNT_W'(STB_CYC))
            sw_d = sw_q + 1'b1;
         strobe_ok = (sw_q == CNT_W'(STB_CYC - 1));
      end else begin
         sw_d = '0;
      end
      // debounce: the low must stay for DEB_TICKS ms; a short bounce
      // restarts the count, so the button waits out its own chatter
      if (pb_q[1] && !pin_q) begin
         if (tk.tick && deb_q != CNT_W'(DEB_TICKS))
            deb_d = deb_q + 1'b1;
         pb_seen = (deb_q == CNT_W'(DEB_TICKS));
      end else begin
         deb_d = '0;
      end
      unique case (st_q)
         ST_HOLD: begin
            if (!supply_ok) begin
               hold_d = '0;
            end else if (tk.tick) begin
               // one extra tick: the first tick lands at an unknown
               // phase, so HOLD_TICKS whole periods still follow it
               if (hold_q == CNT_W'(HOLD_TICKS)) begin
                  st_d = ST_RUN;
                  wd_d = '0;
                  hold_d = '0;
               end else begin
                  hold_d = hold_q + 1'b1;
               end
            end
         end
         ST_RUN: begin
            if (strobe_ok) begin
               wd_d  = '0;
               exp_d = 1'b0;
            end else if (tk.tick) begin
               if (wd_q == CNT_W'(WDOG_TICKS - 1)) begin
                  st_d   = ST_HOLD;
                  hold_d = '0;
                  exp_d  = 1'b1;
               end else begin
                  wd_d = wd_q + 1'b1;
               end
            end
            if (pb_seen) begin
               st_d = ST_PUSH;
               deb_d = '0;
            end
         end
         ST_PUSH: begin
            // go straight to a full hold, whatever the press length
            st_d   = ST_HOLD;
            hold_d = '0;
         end
         default: st_d = ST_HOLD;
      endcase
      if (!supply_ok) begin
         st_d   = ST_HOLD;
         hold_d = '0;
         exp_d  = 1'b0;
      end
      pin_d = (st_d != ST_RUN) || !supply_good;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q   <= ST_HOLD;
         hold_q <= '0;
         wd_q   <= '0;
         deb_q  <= '0;
         sw_q   <= '0;
         pin_q  <= 1'b1;
         exp_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         hold_q <= hold_d;
         wd_q   <= wd_d;
         deb_q  <= deb_d;
         sw_q   <= sw_d;
         pin_q  <= pin_d;
         exp_q  <= exp_d;
      end
   end

   // ==========================================================
   // open-drain pin: data fixed low, only the enable moves
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reset_strobe_pin_o  <= 1'b0;
         reset_strobe_pin_oe <= 1'b1;
         wdog_expired        <= 1'b0;
      end else begin
         reset_strobe_pin_o  <= 1'b0;
         reset_strobe_pin_oe <= pin_d;
         wdog_expired        <= exp_d;
      end
   end
endmodule
`default_nettype wire

/* File: verif/sup_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// supervisor checker
module sup_monitor #(
   parameter int unsigned TICK_CYC   = 10,
   parameter int unsigned HOLD_TICKS = 5,
   parameter int unsigned WDOG_TICKS = 7,
   parameter int unsigned DEB_TICKS  = 2
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic supply_good,
   input wire logic strobe_low_level,
   input wire logic push_button_reset,
   input wire logic reset_strobe_pin_o,
   input wire logic reset_strobe_pin_oe,
   input wire logic wdog_expired
);
   localparam int HOLD_C = HOLD_TICKS * TICK_CYC;
   localparam int WD_LO  = (WDOG_TICKS - 2) * TICK_CYC;
   localparam int WD_HI  = (WDOG_TICKS + 1) * TICK_CYC + 2;
   localparam int PB_HI  = (DEB_TICKS + 1) * TICK_CYC + 5;
   int hi_q;
   int quiet_q;
   int run_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // tick phase is unknown, so the upper bounds carry one tick of slack and the early bound two
   always_ff @(posedge ref_clk) begin
      hi_q    <= (!resetn || !reset_strobe_pin_oe) ? 0 : hi_q + 1;
      quiet_q <= (!resetn || reset_strobe_pin_oe || strobe_low_level ||
                  push_button_reset) ? 0 : quiet_q + 1;
      run_q   <= (!resetn || reset_strobe_pin_oe || !push_button_reset) ?
                 0 : run_q + 1;
   end
   chk_supply_low_pull: assert property (
      !supply_good |=> reset_strobe_pin_oe) else $error("supply low no pull");
   chk_pin_never_high: assert property (
      !reset_strobe_pin_o) else $error("pin driven high");
   chk_pulse_min_len: assert property (
      $fell(reset_strobe_pin_oe) |-> hi_q >= HOLD_C)
      else $error("reset pulse too short");
   chk_wdog_late: assert property (
      quiet_q <= WD_HI) else $error("watchdog late");
   chk_wdog_early: assert property (
      supply_good && !push_button_reset && quiet_q > 4 && quiet_q < WD_LO
      |=> !reset_strobe_pin_oe) else $error("watchdog early");
   chk_own_mask: assert property (
      $fell(reset_strobe_pin_oe) |=>
      (!reset_strobe_pin_oe || !$past(supply_good)) [*6])
      else $error("own drive retriggered");
   chk_push_reacts: assert property (
      run_q <= PB_HI) else $error("push not taken");
   chk_expired_pulse: assert property (
      $rose(wdog_expired) |-> reset_strobe_pin_oe)
      else $error("expiry without pulse");
   cover property ($rose(wdog_expired));
   cover property (run_q == 15);
   cover property (!supply_good ##1 supply_good);
endmodule
`default_nettype wire

/* File: verif/proc_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// processor strobe line and push button on the shared pin
module proc_model (
   input  wire logic pin_oe,
   input  wire logic stb_req,
   input  wire logic btn_req,
   output wire logic strobe_low_level,
   output wire logic push_button_reset
);
   // own pull-down beats the divider, so the pin then reads deep low
   assign push_button_reset = pin_oe | btn_req;
   assign strobe_low_level  = !pin_oe & !btn_req & stb_req;
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
$display("MISMATCH %s exp %0d got %0d", nm, e, g); end end
// ====================
// bench top
module tb_top;
   localparam int HC = 50;
   localparam int WC = 70;
   logic      ref_clk, resetn, sup, stb, btn;
   wire logic stl, pbr, pin_o, oe, exp_q;
   int        n_fail, checks_done, cyc, n;
   initial begin
      ref_clk = 0;
      forever #20 ref_clk = ~ref_clk;
   end
   supply_watchdog_reset_supervisor #(.TICK_CYC(10), .HOLD_TICKS(5),
      .WDOG_TICKS(7), .DEB_TICKS(2), .STB_CYC(13)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .supply_good(sup),
      .strobe_low_level(stl), .push_button_reset(pbr),
      .reset_strobe_pin_o(pin_o), .reset_strobe_pin_oe(oe),
      .wdog_expired(exp_q));
   proc_model partner (.pin_oe(oe), .stb_req(stb), .btn_req(btn),
      .strobe_low_level(stl), .push_button_reset(pbr));
   task automatic cyc_n(input int k);
      repeat (k) @(negedge ref_clk);
   endtask
   task automatic wait_oe(input logic v, output int k);
      k = 0;
      while (oe !== v && k < 400) begin
         @(negedge ref_clk);
         k++;
      end
   endtask
   task automatic t_power;
      sup = 0;
      cyc_n(1);
      `CHK("oe_supply_low", 1'b1, oe)
      cyc_n(20);
      sup = 1;
      wait_oe(1'b0, n);
      `CHK("hold_len", 1'b1, n >= HC)
   endtask
   task automatic t_strobe;
      repeat (5) begin
         stb = 1;
         cyc_n(20);
         stb = 0;
         cyc_n(25);
         `CHK("strobed_no_reset", 1'b0, oe)
      end
      wait_oe(1'b1, n);
      // about 30 cycles have passed since the last strobe was taken
      `CHK("timeout", 1'b1, n + 30 >= HC && n + 30 <= WC + 20)
      `CHK("expired", 1'b1, exp_q)
      wait_oe(1'b0, n);
      `CHK("wd_pulse_len", 1'b1, n >= HC)
      wait_oe(1'b1, n);
      `CHK("repeat", 1'b1, n >= WC - 10 && n <= WC + 10)
      wait_oe(1'b0, n);
      stb = 1;
      cyc_n(20);
      stb = 0;
      `CHK("expired_clear", 1'b0, exp_q)
   endtask
   task automatic t_push;
      repeat (3) begin
         btn = 1;
         cyc_n(5);
         btn = 0;
         cyc_n(3);
      end
      `CHK("bounce", 1'b0, oe)
      btn = 1;
      cyc_n(30);
      btn = 0;
      `CHK("push_reset", 1'b1, oe)
      wait_oe(1'b0, n);
      `CHK("push_len", 1'b1, n >= HC - 30)
      cyc_n(30);
      `CHK("own_masked", 1'b0, oe)
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // hang guard: whole run needs about 750 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report;
      end
   end
   initial begin
      resetn = 0;
      sup = 1;
      stb = 0;
      btn = 0;
      cyc_n(6);
      resetn = 1;
      `CHK("pin_data", 1'b0, pin_o)
      wait_oe(1'b0, n);
      `CHK("powerup_hold", 1'b1, n >= HC)
      t_power;
      t_strobe;
      t_push;
      final_report;
   end
endmodule
bind supply_watchdog_reset_supervisor sup_monitor #(.TICK_CYC(TICK_CYC),
   .HOLD_TICKS(HOLD_TICKS), .WDOG_TICKS(WDOG_TICKS), .DEB_TICKS(DEB_TICKS))
   mon (.ref_clk(ref_clk), .resetn(resetn), .supply_good(supply_good),
   .strobe_low_level(strobe_low_level),
   .push_button_reset(push_button_reset),
   .reset_strobe_pin_o(reset_strobe_pin_o),
   .reset_strobe_pin_oe(reset_strobe_pin_oe), .wdog_expired(wdog_expired));
`default_nettype wire
